// file: hdl/qsb_core.sv
/*
 two-word burst sram core with separate read and write data ports and the
 write burst buffer in front of its array.
 assumes the true and complementary input clocks, selects, address and
 write data arrive as pins much slower than clk_i (each clock phase spans
 at least four clk_i cycles) and are oversampled here.
*/
// Overview of operation
// - read and write addresses alternate on true-clock rises
// - each address carries two words as a burst
// - data moves on rises of both input clocks
// - only rising input-clock edges move read and write data at the ports
// - read data follows request by two cycles
// - read and write ports run concurrently, independently
// - all inputs captured in input registers first
// - all data outputs launched from output registers
// - array writes are internally self-timed
// - separate selects gate read and write ports
// - complementary echo clocks accompany read data
// - reads return the most recently written data
`default_nettype none

module qsb_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // filling side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   // draining side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o,
   // contents by age, oldest at index 0
   output logic [D-1:0][W-1:0] peek_o,
   output logic [D-1:0] live_o
);
   localparam int PW = $clog2(D);
   localparam int CW = $clog2(D + 1);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [CW-1:0] cnt;
   } qsb_fifo_s;

   qsb_fifo_s st_q, st_d;
   logic push, pop;

   // pointer and occupancy update, honest full and empty
   always_comb begin
      st_d = st_q;
      in_ready_o = (st_q.cnt != CW'(D));
      out_valid_o = (st_q.cnt != '0);
      out_data_o = st_q.mem[st_q.rp];
      push = in_valid_i && in_ready_o;
      pop = out_valid_o && out_ready_i;
      if (push) begin
         st_d.mem[st_q.wp] = in_data_i;
         st_d.wp = st_q.wp + PW'(1);
      end
      if (pop) begin
         st_d.rp = st_q.rp + PW'(1);
      end
      st_d.cnt = st_q.cnt + CW'(push) - CW'(pop);
      for (int i = 0; i < D; i++) begin
         peek_o[i] = st_q.mem[PW'(st_q.rp + PW'(i))];
         live_o[i] = (CW'(i) < st_q.cnt);
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule

module qsb_core (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // input clock pair
   input wire logic k_i,
   input wire logic k_n_i,
   // shared address and port selects
   input wire logic [qsb_pkg::AW-1:0] addr_i,
   input wire logic read_sel_n_i,
   input wire logic write_sel_n_i,
   // write data port
   input wire logic [qsb_pkg::DW-1:0] wdata_i,
   output logic wr_ready_o,
   // read data port and echo_clock_pair
   output logic [qsb_pkg::DW-1:0] rdata_o,
   output logic rdata_valid_o,
   output logic echo_clk_o,
   output logic echo_clk_n_o
);
   import qsb_pkg::*;

   typedef struct packed {
      qsb_pins_s s1;
      qsb_pins_s s2;
      logic k_prev;
      logic kn_prev;
      logic slot_wr;
      qsb_rd_s rp0;
      qsb_rd_s rp1;
      qsb_rd_s ro;
      qsb_wb_e wb;
      logic [AW-1:0] wb_addr;
      logic [DW-1:0] wb_d0;
      logic push_v;
      qsb_burst_s push_b;
      logic [WCW-1:0] wcnt;
      logic [DW-1:0] q;
      logic q_v;
      logic echo;
      logic echo_n;
      logic ready;
   } qsb_core_s;

   qsb_core_s st_q, st_d;
   logic [2*DW-1:0] array_mem [2**AW];
   logic krise, knrise, fin_ready, fout_valid, pop;
   logic [$bits(qsb_burst_s)-1:0] fout_w;
   logic [FIFO_DEPTH-1:0][$bits(qsb_burst_s)-1:0] peek_w;
   logic [FIFO_DEPTH-1:0] live_w;
   qsb_burst_s fout;
   logic [2*DW-1:0] hit0, hit1;

   // newest matching buffered write overrides the array
   function automatic logic [2*DW-1:0] lookup(input logic [AW-1:0] a);
      logic [2*DW-1:0] r;
      qsb_burst_s e;
      r = array_mem[a];
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         e = qsb_burst_s'(peek_w[i]);
         if (live_w[i] && e.addr == a) begin
            r = {e.d1, e.d0};
         end
      end
      return r;
   endfunction

   qsb_fifo #(
      .W($bits(qsb_burst_s)),
      .D(FIFO_DEPTH)
   ) u_wbuf (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .in_valid_i(st_q.push_v),
      .in_ready_o(fin_ready),
      .in_data_i(st_q.push_b),
      .out_valid_o(fout_valid),
      .out_ready_i(pop),
      .out_data_o(fout_w),
      .peek_o(peek_w),
      .live_o(live_w)
   );

   // rising edges only, on the captured pin copies
   assign krise = st_q.s2.k && !st_q.k_prev;
   assign knrise = st_q.s2.k_n && !st_q.kn_prev;
   assign fout = qsb_burst_s'(fout_w);
   // a burst leaves the buffer only when its write time has run out
   assign pop = fout_valid && (st_q.wcnt == WCW'(WR_CYC - 1));

   // coherent lookups, redone whenever the buffer or the array moves
   always_comb begin
      hit0 = lookup(st_q.rp1.addr);
      hit1 = lookup(st_q.ro.addr);
   end

   // next-state logic
   always_comb begin
      st_d = st_q;
      // two-flop capture of every pin
      st_d.s1 = {k_i, k_n_i, read_sel_n_i, write_sel_n_i, addr_i, wdata_i};
      st_d.s2 = st_q.s1;
      st_d.k_prev = st_q.s2.k;
      st_d.kn_prev = st_q.s2.k_n;
      // echoes follow the input clocks
      st_d.echo = st_q.s2.k;
      st_d.echo_n = st_q.s2.k_n;
      st_d.ready = fin_ready;
      st_d.push_v = 1'b0;
      st_d.q_v = 1'b0;
      // self-timed write engine, one burst per WR_CYC cycles
      if (fout_valid) begin
         st_d.wcnt = pop ? '0 : st_q.wcnt + WCW'(1);
      end
      if (krise) begin
         st_d.slot_wr = !st_q.slot_wr;
         // read pipeline advances once per true-clock cycle
         st_d.rp1 = st_q.rp0;
         st_d.rp0.v = !st_q.slot_wr && !st_q.s2.read_sel_n;
         st_d.rp0.addr = st_q.s2.addr;
         st_d.ro = st_q.rp1;
         if (st_q.rp1.v) begin
            st_d.q = hit0[DW-1:0];
            st_d.q_v = 1'b1;
         end
         // write port runs beside the read port
         if (st_q.wb == WB_HIGH) begin
            st_d.push_b = '{addr: st_q.wb_addr, d1: st_q.s2.wdata, d0: st_q.wb_d0};
            st_d.push_v = 1'b1;
            st_d.wb = WB_IDLE;
         end
         if (st_q.slot_wr && !st_q.s2.write_sel_n) begin
            st_d.wb = WB_LOW;
            st_d.wb_addr = st_q.s2.addr;
         end
      end
      if (knrise) begin
         // second read word and first write word of each burst on the complementary clock
         if (st_q.ro.v) begin
            st_d.q = hit1[2*DW-1:DW];
            st_d.q_v = 1'b1;
            st_d.ro.v = 1'b0;
         end
         if (st_q.wb == WB_LOW) begin
            st_d.wb_d0 = st_q.s2.wdata;
            st_d.wb = WB_HIGH;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         st_q <= '0;
         st_q.wb <= WB_IDLE;
         st_q.q <= DATA_RST;
         st_q.wb_addr <= ADDR_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // array update when a burst completes its write time
   always_ff @(posedge clk_i) begin
      if (pop) begin
         array_mem[fout.addr] <= {fout.d1, fout.d0};
      end
   end

   assign rdata_o = st_q.q;
   assign rdata_valid_o = st_q.q_v;
   assign echo_clk_o = st_q.echo;
   assign echo_clk_n_o = st_q.echo_n;
   assign wr_ready_o = st_q.ready;

   // slot alternates on every true-clock rise
   property p_slot_alt;
      @(posedge clk_i) disable iff (reset_i) krise |=> st_q.slot_wr != $past(st_q.slot_wr);
   endproperty
   a_slot_alt: assert property (p_slot_alt) else $error("slot did not alternate");

   // a captured read reaches the last stage one cycle on
   property p_rd_pipe;
      @(posedge clk_i) disable iff (reset_i) krise && st_q.rp0.v |=> st_q.rp1.v;
   endproperty
   a_rd_pipe: assert property (p_rd_pipe) else $error("read lost in pipeline");

   // last stage launches the first word with the newest data
   property p_rd_word0;
      @(posedge clk_i) disable iff (reset_i)
         krise && st_q.rp1.v |=> rdata_valid_o && rdata_o == $past(hit0[DW-1:0]);
   endproperty
   a_rd_word0: assert property (p_rd_word0) else $error("first read word wrong");

   // second word on the next complementary rise
   property p_rd_word1;
      @(posedge clk_i) disable iff (reset_i)
         knrise && st_q.ro.v |=> rdata_valid_o ##1 !rdata_valid_o;
   endproperty
   a_rd_word1: assert property (p_rd_word1) else $error("second read word missing");

   // without a rising input-clock edge read data holds and its valid stays low
   property p_rise_only;
      @(posedge clk_i) disable iff (reset_i) !krise && !knrise |=> $stable(rdata_o) && !rdata_valid_o;
   endproperty
   a_rise_only: assert property (p_rise_only) else $error("output moved off a rise");

   // echo pair repeats the input clock pins three cycles late
   property p_echo;
      @(posedge clk_i) disable iff (reset_i)
         echo_clk_o == $past(k_i, 3) && echo_clk_n_o == $past(k_n_i, 3);
   endproperty
   a_echo: assert property (p_echo) else $error("echo clock out of step");

   // deselected read slot captures nothing
   property p_rsel;
      @(posedge clk_i) disable iff (reset_i)
         krise && !st_q.slot_wr && st_q.s2.read_sel_n |=> !st_q.rp0.v;
   endproperty
   a_rsel: assert property (p_rsel) else $error("read taken while deselected");

   // completed burst enters the buffer one cycle later
   property p_push;
      @(posedge clk_i) disable iff (reset_i) krise && st_q.wb == WB_HIGH |=> st_q.push_v;
   endproperty
   a_push: assert property (p_push) else $error("write burst not queued");

   // write engine restarts its timer after each array write
   property p_self_timed;
      @(posedge clk_i) disable iff (reset_i) pop |=> st_q.wcnt == '0 && !pop;
   endproperty
   a_self_timed: assert property (p_self_timed) else $error("array write too early");

   // first write word taken on the complementary rise
   property p_wr_word0;
      @(posedge clk_i) disable iff (reset_i)
         knrise && st_q.wb == WB_LOW
         |=> st_q.wb == WB_HIGH && st_q.wb_d0 == $past(st_q.s2.wdata);
   endproperty
   a_wr_word0: assert property (p_wr_word0) else $error("word0 not taken");

   // deselected write slot opens no burst
   property p_wsel;
      @(posedge clk_i) disable iff (reset_i)
         krise && st_q.slot_wr && st_q.s2.write_sel_n |=> st_q.wb == WB_IDLE;
   endproperty
   a_wsel: assert property (p_wsel) else $error("write taken while deselected");

   // write slots never start a read
   property p_rd_slot;
      @(posedge clk_i) disable iff (reset_i) krise && st_q.slot_wr |=> !st_q.rp0.v;
   endproperty
   a_rd_slot: assert property (p_rd_slot) else $error("read in a write slot");

   // read data only moves together with its valid pulse
   property p_q_launch;
      @(posedge clk_i) disable iff (reset_i) !rdata_valid_o |-> rdata_o == $past(rdata_o);
   endproperty
   a_q_launch: assert property (p_q_launch) else $error("data moved alone");
endmodule
`default_nettype wire

// file: hdl/qsb_pkg.sv
/*
 package of the two-word burst separate-port sram core: widths, timing
 counts and the packed carriers shared by the core and its write buffer.
 assumes a single 20 mhz system clock that oversamples the memory pins.
*/
`default_nettype none
package qsb_pkg;
   // x18 configuration: 4m words, two per address
   localparam int DW = 18;
   localparam int AW = 21;
   // system clock rate and self-timed array write time per burst
   localparam int CLK_MHZ = 20;
   localparam int WRITE_NS = 100;
   localparam int WR_CYC = (WRITE_NS * CLK_MHZ + 999) / 1000;
   localparam int WCW = 3;
   // read latency in input-clock (true clock) cycles
   localparam int RD_LAT = 2;
   // depth of the write burst buffer
   localparam int FIFO_DEPTH = 8;
   // reset values
   localparam logic [DW-1:0] DATA_RST = 18'h00000;
   localparam logic [AW-1:0] ADDR_RST = 21'h000000;

   // memory pins after capture
   typedef struct packed {
      logic k;
      logic k_n;
      logic read_sel_n;
      logic write_sel_n;
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
   } qsb_pins_s;

   // one complete write burst: first word low
   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] d1;
      logic [DW-1:0] d0;
   } qsb_burst_s;

   // a pending read
   typedef struct packed {
      logic v;
      logic [AW-1:0] addr;
   } qsb_rd_s;

   // write assembly phase
   typedef enum logic [2:0] {
      WB_IDLE = 3'b001,
      WB_LOW = 3'b010,
      WB_HIGH = 3'b100
   } qsb_wb_e;
endpackage
`default_nettype wire

// file: testbench/qsb_host.sv
/*
 host memory controller model: drives the input clock pair, shared address,
 port selects and write data. assumes the bench's clk_i and a 6-cycle phase.
*/
`default_nettype none
module qsb_host (
   // system clock
   input wire logic clk_i,
   // memory pins
   output logic k_o,
   output logic k_n_o,
   output logic [qsb_pkg::AW-1:0] addr_o,
   output logic read_sel_n_o,
   output logic write_sel_n_o,
   output logic [qsb_pkg::DW-1:0] wdata_o
);
   timeunit 1ns;
   timeprecision 1ns;
   import qsb_pkg::*;
   int rises;
   logic [DW-1:0] pend_q;
   // pins idle, clock pair low through reset
   initial begin
      {k_o, k_n_o, read_sel_n_o, write_sel_n_o} = 4'h3;
      addr_o = ADDR_RST;
      wdata_o = DATA_RST;
      pend_q = DATA_RST;
      rises = 0;
   end
   // one clock phase: pins set a cycle ahead of the toggle
   task automatic half(input logic kv, input logic [AW-1:0] a, input logic rs,
      input logic ws, input logic [DW-1:0] d);
      repeat (5) @(posedge clk_i);
      addr_o <= a;
      read_sel_n_o <= rs;
      write_sel_n_o <= ws;
      wdata_o <= d;
      @(posedge clk_i);
      k_o <= kv;
      k_n_o <= !kv;
      rises <= rises + 32'(kv);
   endtask
   // read slot then write slot; word1 rides the next read rise
   task automatic pair(input logic rd, input logic [AW-1:0] ra, input logic wr,
      input logic [AW-1:0] wa, input logic [DW-1:0] d0, input logic [DW-1:0] d1);
      half(1'b1, ra, !rd, 1'b1, pend_q);
      half(1'b0, ~ra, 1'b1, 1'b1, ~pend_q);
      half(1'b1, wa, 1'b1, !wr, ~pend_q);
      half(1'b0, ~wa, 1'b1, 1'b1, d0);
      pend_q = d1;
   endtask
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
/*
 testbench of the burst sram core and its fifo, pins driven by the host
 model. assumes a 20 mhz clock and synchronous active-high reset.
*/
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import qsb_pkg::*;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic k, k_n, rsel_n, wsel_n, wr_ready, rvalid, echo, echo_n;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata, rdata;
   logic [DW-1:0] got_d[$], exp_d[$];
   int got_t[$], exp_t[$];
   int n_mismatch = 0;
   int tests_run = 0;
   int stab = 0;
   logic k_prev = 1'b0;
   always #25 clk_i = ~clk_i;
   qsb_host u_host (.clk_i(clk_i), .k_o(k), .k_n_o(k_n), .addr_o(addr),
      .read_sel_n_o(rsel_n), .write_sel_n_o(wsel_n), .wdata_o(wdata));
   qsb_core u_dut (.clk_i(clk_i), .reset_i(reset_i), .k_i(k), .k_n_i(k_n),
      .addr_i(addr), .read_sel_n_i(rsel_n), .write_sel_n_i(wsel_n),
      .wdata_i(wdata), .wr_ready_o(wr_ready), .rdata_o(rdata),
      .rdata_valid_o(rvalid), .echo_clk_o(echo), .echo_clk_n_o(echo_n));
   task automatic chk_word(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_word(DW'(got), DW'(exp));
   endtask
   task automatic chk_cnt(input int got, input int exp);
      tests_run++;
      if (got != exp) begin
         n_mismatch++;
         $display("FAIL %0t count %0d expected %0d", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // capture read words with phase tag; echo checked once clocks settle
   always @(posedge clk_i) begin
      if (!reset_i && rvalid === 1'b1) begin
         got_d.push_back(rdata);
         got_t.push_back(u_host.rises * 2 + (k ? 0 : 1));
      end
      stab <= (k !== k_prev) ? 0 : stab + 1;
      k_prev <= k;
      if (!reset_i && stab == 4) begin
         chk_bit(echo, k);
         chk_bit(echo_n, k_n);
      end
   end
   // one pair of slots; a read expects both words two rises later
   task automatic op(input logic rd, input logic [AW-1:0] ra, input logic wr,
      input logic [AW-1:0] wa, input logic [DW-1:0] d0, input logic [DW-1:0] d1,
      input logic [DW-1:0] e0, input logic [DW-1:0] e1);
      if (rd) begin
         exp_d.push_back(e0);
         exp_d.push_back(e1);
         exp_t.push_back(u_host.rises * 2 + 6);
         exp_t.push_back(u_host.rises * 2 + 7);
      end
      u_host.pair(rd, ra, wr, wa, d0, d1);
   endtask
   task automatic drain;
      repeat (2) op(1'b0, ~ADDR_RST, 1'b0, ~ADDR_RST, DATA_RST, DATA_RST, DATA_RST,
         DATA_RST);
      for (int i = 0; i < 60 && got_d.size() < exp_d.size(); i++) @(posedge clk_i);
      chk_cnt(got_d.size(), exp_d.size());
      if (got_d.size() < exp_d.size()) give_verdict();
      while (exp_d.size() > 0 && got_d.size() > 0) begin
         chk_word(got_d.pop_front(), exp_d.pop_front());
         chk_cnt(got_t.pop_front(), exp_t.pop_front());
      end
      got_d.delete();
      got_t.delete();
      exp_d.delete();
      exp_t.delete();
      chk_bit(wr_ready, 1'b1);
   endtask
   // writes at both address ends, concurrent ports, overwrite
   task automatic test_burst;
      op(0, 21'h000000, 1, 21'h000000, 18'h00011, 18'h00022, DATA_RST, DATA_RST);
      op(0, 21'h000000, 1, 21'h1fffff, 18'h3ffff, 18'h20001, DATA_RST, DATA_RST);
      op(1, 21'h000000, 1, 21'h000005, 18'h15555, 18'h2aaaa, 18'h00011, 18'h00022);
      op(1, 21'h1fffff, 0, 21'h000005, DATA_RST, DATA_RST, 18'h3ffff, 18'h20001);
      op(1, 21'h000005, 1, 21'h000000, 18'h0abcd, 18'h1dcba, 18'h15555, 18'h2aaaa);
      op(0, 21'h000000, 0, 21'h000000, DATA_RST, DATA_RST, DATA_RST, DATA_RST);
      op(1, 21'h000000, 0, 21'h000000, DATA_RST, DATA_RST, 18'h0abcd, 18'h1dcba);
      drain();
      $display("test burst done");
   endtask
   // deselected slots neither answer nor store
   task automatic test_desel;
      op(0, 21'h000000, 0, 21'h000000, 18'h3f0f0, 18'h00f0f, DATA_RST, DATA_RST);
      op(1, 21'h000000, 0, 21'h000000, DATA_RST, DATA_RST, 18'h0abcd, 18'h1dcba);
      drain();
      $display("test desel done");
   endtask
   // eight write bursts back to back through the buffer, then read back in order
   task automatic test_fifo;
      int n;
      n = 0;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         op(0, ADDR_RST, 1, AW'(i) + 21'h000010, DW'(i) + 18'h00100, DW'(i) + 18'h00200,
            DATA_RST, DATA_RST);
         if (wr_ready === 1'b1) n++;
      end
      chk_cnt(n, FIFO_DEPTH);
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         op(1, AW'(i) + 21'h000010, 0, ADDR_RST, DATA_RST, DATA_RST, DW'(i) + 18'h00100,
            DW'(i) + 18'h00200);
      end
      drain();
      chk_word(rdata, 18'h00207);
      chk_bit(rvalid, 1'b0);
      $display("test fifo done");
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      chk_word(rdata, DATA_RST);
      chk_bit(rvalid, 1'b0);
      chk_bit(echo, 1'b0);
      chk_bit(wr_ready, 1'b0);
      reset_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk_bit(wr_ready, 1'b1);
      $display("test reset done");
      test_burst();
      test_desel();
      test_fifo();
      give_verdict();
   end
endmodule
`default_nettype wire
